// ===== verilog/gpio_pkg.sv
// Shared constants, register map and state types for the pin and serial link blocks.
package gpio_pkg;
  // Device register indices, as sent in the byte after the address byte.
  localparam logic [7:0] REG_POLARITY = 8'h00;
  localparam logic [7:0] REG_FUNC0 = 8'h01;
  localparam logic [7:0] REG_FUNC5 = 8'h06;
  localparam logic [7:0] REG_RAIL_CMD = 8'h07;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PHASE = 8'h09;
  localparam logic [7:0] REG_CONFIG = 8'h0a;
  localparam logic [7:0] REG_PIN_OUT = 8'h0b;
  localparam logic [7:0] REG_PIN_IN = 8'h0c;
  // Configuration register bit positions.
  localparam int CFG_THREE_PHASE = 0;
  localparam int CFG_ADDR_FROM_PIN = 1;
  localparam int CFG_EXT_CLOCK = 2;
  // Pin function codes in bits 7:5 of each pin_function_select register.
  localparam logic [2:0] FN_INPUT = 3'h0;
  localparam logic [2:0] FN_OUTPUT = 3'h1;
  localparam logic [2:0] FN_ENABLE = 3'h2;
  localparam logic [2:0] FN_PGOOD = 3'h3;
  localparam logic [2:0] FN_FAULT = 3'h4;
  localparam logic [2:0] FN_EXTCLK = 3'h5;
  // Values after reset, and the phase step sizes in degrees.
  localparam logic [5:0] POL_RESET = 6'h00;
  localparam logic [7:0] FUNC_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [4:0] RAIL_RESET = 5'h00;
  localparam logic [8:0] PHASE_STEP_FOUR = 9'h05a;
  localparam logic [8:0] PHASE_STEP_THREE = 9'h078;
  // Host timing: the host makes the serial clock by dividing its own clock.
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 4000;
  localparam int QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  // Host register offsets on the AXI4-Lite bus.
  localparam logic [7:0] AXI_CMD = 8'h00;
  localparam logic [7:0] AXI_STATUS = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0, DS_ADDR = 3'h1, DS_INDEX = 3'h2, DS_WRITE = 3'h3,
    DS_ACK = 3'h4, DS_READ = 3'h5, DS_MACK = 3'h6
  } dev_state_e;
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0, HS_START = 3'h1, HS_BIT = 3'h2, HS_RSTART = 3'h3, HS_STOP = 3'h4
  } host_state_e;
endpackage

// ===== verilog/gpio_link_if.sv
// Open-drain serial bus and general-purpose pins joining the host and the device.
interface gpio_link_if;
  logic scl_h_o;
  logic scl_h_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic [5:0] gpio_d_o;
  logic [5:0] gpio_d_oe;
  logic [5:0] gpio_s_o;
  logic [5:0] gpio_s_oe;
  logic scl;
  logic sda;
  logic [5:0] gpio;
  // Both lines are pulled up; a driver can only pull low.
  assign scl = !(scl_h_oe && !scl_h_o);
  assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));
  // Pins: device drive wins, then the system side, else the pull-up.
  assign gpio = (gpio_d_o & gpio_d_oe) | (gpio_s_o & gpio_s_oe & ~gpio_d_oe)
              | ~(gpio_d_oe | gpio_s_oe);
  modport device(input scl, sda, gpio, output sda_d_o, sda_d_oe, gpio_d_o, gpio_d_oe);
  modport host(input scl, sda, output scl_h_o, scl_h_oe, sda_h_o, sda_h_oe);
endinterface

// ===== verilog/gpio_i2c_device.sv
// Device end: serial slave, pin functions, polarity, rail enables and clock selection.
module gpio_i2c_device (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial bus and pins
  gpio_link_if.device link,
  // Straps and nonvolatile store
  input wire logic two_wire_mode,
  input wire logic [6:0] nv_address,
  input wire logic otp_valid,
  input wire logic [47:0] otp_pin_function,
  // Regulator state
  input wire logic [4:0] rail_good,
  input wire logic [3:0] softstart_done,
  input wire logic [3:0] overcurrent_fault,
  input wire logic [3:0] overcurrent_warn,
  input wire logic [3:0] overvoltage_fault,
  input wire logic [1:0] input_undervoltage_fault,
  input wire logic [1:0] input_undervoltage_warn,
  input wire logic over_temp,
  // Controls
  output logic [4:0] rail_on,
  output logic [35:0] phase_offset_deg,
  output logic main_clock_external,
  output logic ext_sync_clock,
  output logic config_loaded
);
  // Three-stage synchronisers for scl, sda and the six pins.
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] sync3;
  logic [7:0] filt;
  logic [7:0] filt_q;
  // Registers.
  logic [5:0] pin_polarity_select;
  logic [7:0] pin_function_select [6];
  logic [4:0] rail_command;
  logic [7:0] phase_select;
  logic [7:0] config_bits;
  logic [5:0] pin_out_data;
  logic [6:0] addr_base;
  // Serial engine.
  gpio_pkg::dev_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] idx;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic wr_stb;
  logic rd_dir;
  logic have_idx;
  logic master_ack;
  logic sda_pull;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1 <= 8'hff;
      sync2 <= 8'hff;
      sync3 <= 8'hff;
      filt <= 8'hff;
      filt_q <= 8'hff;
    end else begin
      sync1 <= {link.gpio, link.sda, link.scl};
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= (sync2 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
      filt_q <= filt;
    end
  end

  wire scl_f = filt[0];
  wire sda_f = filt[1];
  wire [5:0] pin_lvl = filt[7:2];
  wire scl_rise = scl_f && !filt_q[0];
  wire scl_fall = !scl_f && filt_q[0];
  wire bus_start = scl_f && filt_q[0] && filt_q[1] && !sda_f;
  wire bus_stop = scl_f && filt_q[0] && !filt_q[1] && sda_f;
  wire [6:0] addr_eff = {addr_base[6:1],
    config_bits[gpio_pkg::CFG_ADDR_FROM_PIN] ? pin_lvl[3] : addr_base[0]};
  wire addr_match = shreg[7:1] == addr_eff;
  wire [5:0] logical_in = pin_lvl ^ pin_polarity_select;
  wire [31:0] fault_vec = {15'h0, over_temp, input_undervoltage_warn,
    input_undervoltage_fault, overvoltage_fault, overcurrent_warn, overcurrent_fault};

  // Per-pin decode, accumulated across pins.
  logic [4:0] en_acc [7];
  logic [6:0] clk_acc;
  logic [5:0] drive_val;
  logic [5:0] drive_oe;
  assign en_acc[0] = 5'h00;
  assign clk_acc[0] = 1'b0;
  for (genvar i = 0; i < 6; i++) begin : g_pin
    wire [2:0] fn = pin_function_select[i][7:5];
    wire [4:0] sel = pin_function_select[i][4:0];
    wire pg_ok = ((rail_good & sel) == sel) && (sel != 5'h00);
    wire bus_pin = two_wire_mode && (i >= 4);
    assign drive_val[i] = (fn == gpio_pkg::FN_OUTPUT) ? pin_out_data[i] :
                          (fn == gpio_pkg::FN_PGOOD) ? pg_ok : fault_vec[sel];
    assign drive_oe[i] = !bus_pin && (fn == gpio_pkg::FN_OUTPUT ||
                         fn == gpio_pkg::FN_PGOOD || fn == gpio_pkg::FN_FAULT);
    assign en_acc[i + 1] = en_acc[i] |
      ((fn == gpio_pkg::FN_ENABLE && logical_in[i]) ? sel : 5'h00);
    assign clk_acc[i + 1] = clk_acc[i] |
      (fn == gpio_pkg::FN_EXTCLK && logical_in[i]);
  end

  // Phase offset in degrees for each channel from its two-bit step count.
  function automatic logic [8:0] phase_deg(input logic [1:0] k, input logic three);
    logic [8:0] step;
    step = three ? gpio_pkg::PHASE_STEP_THREE : gpio_pkg::PHASE_STEP_FOUR;
    case (k)
      2'h1: phase_deg = step;
      2'h2: phase_deg = 9'(step << 1);
      2'h3: phase_deg = three ? 9'h000 : 9'(step + (step << 1));
      default: phase_deg = 9'h000;
    endcase
  endfunction

  // Register read selection.
  wire func_hit = idx >= gpio_pkg::REG_FUNC0 && idx <= gpio_pkg::REG_FUNC5;
  wire [2:0] func_idx = 3'(idx - gpio_pkg::REG_FUNC0);
  wire [7:0] reg_rdata =
    (idx == gpio_pkg::REG_POLARITY) ? {2'h0, pin_polarity_select} :
    func_hit ? pin_function_select[func_idx] :
    (idx == gpio_pkg::REG_RAIL_CMD) ? {3'h0, rail_command} :
    (idx == gpio_pkg::REG_STATUS) ? {softstart_done, rail_good[3:0]} :
    (idx == gpio_pkg::REG_PHASE) ? phase_select :
    (idx == gpio_pkg::REG_CONFIG) ? config_bits :
    (idx == gpio_pkg::REG_PIN_OUT) ? {2'h0, pin_out_data} :
    (idx == gpio_pkg::REG_PIN_IN) ? {2'h0, logical_in} : 8'h00;
  wire wfunc_hit = wr_idx >= gpio_pkg::REG_FUNC0 && wr_idx <= gpio_pkg::REG_FUNC5;
  wire [2:0] wfunc_idx = 3'(wr_idx - gpio_pkg::REG_FUNC0);

  // Register file; the first cycle after reset loads the nonvolatile contents.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      config_loaded <= 1'b0;
      pin_polarity_select <= gpio_pkg::POL_RESET;
      for (int i = 0; i < 6; i++) pin_function_select[i] <= gpio_pkg::FUNC_RESET;
      rail_command <= gpio_pkg::RAIL_RESET;
      phase_select <= gpio_pkg::BYTE_RESET;
      config_bits <= gpio_pkg::BYTE_RESET;
      pin_out_data <= 6'h00;
      addr_base <= 7'h00;
    end else if (!config_loaded) begin
      config_loaded <= 1'b1;
      addr_base <= nv_address;
      if (otp_valid) begin
        for (int i = 0; i < 6; i++) pin_function_select[i] <= otp_pin_function[8*i +: 8];
      end
    end else if (wr_stb) begin
      if (wr_idx == gpio_pkg::REG_POLARITY) begin
        pin_polarity_select[3:0] <= wr_data[3:0];
        if (!two_wire_mode) pin_polarity_select[5:4] <= wr_data[5:4];
      end
      if (wfunc_hit) pin_function_select[wfunc_idx] <= wr_data;
      if (wr_idx == gpio_pkg::REG_RAIL_CMD) rail_command <= wr_data[4:0];
      if (wr_idx == gpio_pkg::REG_PHASE) phase_select <= wr_data;
      if (wr_idx == gpio_pkg::REG_CONFIG) config_bits <= wr_data;
      if (wr_idx == gpio_pkg::REG_PIN_OUT) pin_out_data <= wr_data[5:0];
    end
  end

  // Registered outputs.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link.gpio_d_o <= 6'h00;
      link.gpio_d_oe <= 6'h00;
      link.sda_d_o <= 1'b0;
      link.sda_d_oe <= 1'b0;
      rail_on <= 5'h00;
      phase_offset_deg <= 36'h0;
      main_clock_external <= 1'b0;
      ext_sync_clock <= 1'b0;
    end else begin
      link.gpio_d_o <= drive_val ^ pin_polarity_select;
      link.gpio_d_oe <= drive_oe;
      link.sda_d_o <= 1'b0;
      link.sda_d_oe <= sda_pull;
      rail_on <= rail_command | en_acc[6];
      for (int c = 0; c < 4; c++) begin
        phase_offset_deg[9*c +: 9] <= phase_deg(phase_select[2*c +: 2],
          config_bits[gpio_pkg::CFG_THREE_PHASE]);
      end
      main_clock_external <= config_loaded && config_bits[gpio_pkg::CFG_EXT_CLOCK];
      ext_sync_clock <= clk_acc[6];
    end
  end

  // Serial slave: address, index, then data bytes with auto-increment.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= gpio_pkg::DS_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      idx <= 8'h00;
      wr_idx <= 8'h00;
      wr_data <= 8'h00;
      wr_stb <= 1'b0;
      rd_dir <= 1'b0;
      have_idx <= 1'b0;
      master_ack <= 1'b0;
      sda_pull <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (bus_start) begin
        state <= gpio_pkg::DS_ADDR;
        bit_cnt <= 4'h0;
        sda_pull <= 1'b0;
        have_idx <= 1'b0;
      end else if (bus_stop) begin
        state <= gpio_pkg::DS_IDLE;
        sda_pull <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          gpio_pkg::DS_ADDR, gpio_pkg::DS_INDEX, gpio_pkg::DS_WRITE: begin
            shreg <= {shreg[6:0], sda_f};
            bit_cnt <= bit_cnt + 4'h1;
          end
          gpio_pkg::DS_READ: bit_cnt <= bit_cnt + 4'h1;
          gpio_pkg::DS_MACK: master_ack <= !sda_f;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          gpio_pkg::DS_ADDR: if (bit_cnt == 4'h8) begin
            if (addr_match) begin
              sda_pull <= 1'b1;
              rd_dir <= shreg[0];
              state <= gpio_pkg::DS_ACK;
            end else begin
              state <= gpio_pkg::DS_IDLE;
            end
          end
          gpio_pkg::DS_INDEX: if (bit_cnt == 4'h8) begin
            idx <= shreg;
            have_idx <= 1'b1;
            sda_pull <= 1'b1;
            state <= gpio_pkg::DS_ACK;
          end
          gpio_pkg::DS_WRITE: if (bit_cnt == 4'h8) begin
            wr_stb <= 1'b1;
            wr_idx <= idx;
            wr_data <= shreg;
            idx <= idx + 8'h01;
            sda_pull <= 1'b1;
            state <= gpio_pkg::DS_ACK;
          end
          gpio_pkg::DS_ACK: begin
            bit_cnt <= 4'h0;
            if (rd_dir) begin
              shreg <= reg_rdata;
              sda_pull <= !reg_rdata[7];
              idx <= idx + 8'h01;
              state <= gpio_pkg::DS_READ;
            end else begin
              sda_pull <= 1'b0;
              state <= have_idx ? gpio_pkg::DS_WRITE : gpio_pkg::DS_INDEX;
            end
          end
          gpio_pkg::DS_READ: begin
            if (bit_cnt == 4'h8) begin
              sda_pull <= 1'b0;
              state <= gpio_pkg::DS_MACK;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              sda_pull <= !shreg[6];
            end
          end
          gpio_pkg::DS_MACK: begin
            bit_cnt <= 4'h0;
            if (master_ack) begin
              shreg <= reg_rdata;
              sda_pull <= !reg_rdata[7];
              idx <= idx + 8'h01;
              state <= gpio_pkg::DS_READ;
            end else begin
              state <= gpio_pkg::DS_IDLE;
            end
          end
          default: state <= gpio_pkg::DS_IDLE;
        endcase
      end
    end
  end
endmodule

// ===== verilog/gpio_i2c_host.sv
// Host end: AXI4-Lite command registers driving a serial bus master.
module gpio_i2c_host (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial bus
  gpio_link_if.host link
);
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  gpio_pkg::host_state_e state;
  logic [1:0] phase;
  logic [7:0] q_cnt;
  logic [3:0] bitn;
  logic [2:0] byte_no;
  logic [7:0] tx;
  logic [7:0] rx;
  logic nack;
  logic busy;
  logic is_read;
  logic [6:0] dev_addr;
  logic [7:0] index;
  logic [7:0] wbyte;

  wire tick = busy && (q_cnt == 8'h00);
  wire tx_mode = byte_no != 3'h4;
  wire cmd_go = aw_addr == gpio_pkg::AXI_CMD && w_strb[3] && w_data[31] && !busy;
  wire aw_ok = aw_addr == gpio_pkg::AXI_CMD || aw_addr == gpio_pkg::AXI_STATUS;
  wire ar_ok = s_axi_araddr == gpio_pkg::AXI_CMD || s_axi_araddr == gpio_pkg::AXI_STATUS;
  wire [31:0] status_word = {16'h0, rx, 6'h0, nack, busy};
  wire [31:0] cmd_word = {7'h0, is_read, 1'b0, dev_addr, index, wbyte};
  wire [31:0] rd_word = (s_axi_araddr == gpio_pkg::AXI_STATUS) ? status_word :
                        (s_axi_araddr == gpio_pkg::AXI_CMD) ? cmd_word : 32'h0;

  // Bus slave: address and data taken in either order, response after both.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= gpio_pkg::RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= gpio_pkg::RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
        aw_got <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_got <= 1'b1;
      end
      if (aw_got && w_got) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aw_ok ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= ar_ok ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Bus master: each bit is four quarter periods of the divided clock.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= gpio_pkg::HS_IDLE;
      phase <= 2'h0;
      q_cnt <= 8'h00;
      bitn <= 4'h0;
      byte_no <= 3'h0;
      tx <= 8'h00;
      rx <= 8'h00;
      nack <= 1'b0;
      busy <= 1'b0;
      is_read <= 1'b0;
      dev_addr <= 7'h00;
      index <= 8'h00;
      wbyte <= 8'h00;
      link.scl_h_o <= 1'b0;
      link.scl_h_oe <= 1'b0;
      link.sda_h_o <= 1'b0;
      link.sda_h_oe <= 1'b0;
    end else begin
      if (aw_got && w_got && cmd_go) begin
        busy <= 1'b1;
        is_read <= w_data[24];
        dev_addr <= w_data[22:16];
        index <= w_data[15:8];
        wbyte <= w_data[7:0];
        nack <= 1'b0;
        phase <= 2'h0;
        q_cnt <= 8'h00;
        state <= gpio_pkg::HS_START;
      end else if (busy) begin
        q_cnt <= tick ? 8'(gpio_pkg::QUARTER_CYCLES - 1) : q_cnt - 8'h01;
      end
      if (tick) begin
        phase <= phase + 2'h1;
        case (state)
          gpio_pkg::HS_START: begin
            if (phase == 2'h1) link.sda_h_oe <= 1'b1;
            if (phase == 2'h2) link.scl_h_oe <= 1'b1;
            if (phase == 2'h3) begin
              tx <= {dev_addr, 1'b0};
              bitn <= 4'h0;
              byte_no <= 3'h0;
              state <= gpio_pkg::HS_BIT;
            end
          end
          gpio_pkg::HS_BIT: begin
            if (phase == 2'h0) link.sda_h_oe <= tx_mode && bitn < 4'h8 && !tx[7];
            if (phase == 2'h1) link.scl_h_oe <= 1'b0;
            if (phase == 2'h2) begin
              if (bitn == 4'h8 && tx_mode) nack <= link.sda;
              else if (bitn < 4'h8 && !tx_mode) rx <= {rx[6:0], link.sda};
            end
            if (phase == 2'h3) begin
              link.scl_h_oe <= 1'b1;
              tx <= {tx[6:0], 1'b0};
              bitn <= bitn + 4'h1;
              if (bitn == 4'h8) begin
                bitn <= 4'h0;
                if ((tx_mode && nack) || byte_no == 3'h2 || byte_no == 3'h4) begin
                  state <= gpio_pkg::HS_STOP;
                end else if (byte_no == 3'h1 && is_read) begin
                  state <= gpio_pkg::HS_RSTART;
                end else begin
                  byte_no <= byte_no + 3'h1;
                  tx <= (byte_no == 3'h0) ? index : wbyte;
                end
              end
            end
          end
          gpio_pkg::HS_RSTART: begin
            if (phase == 2'h0) link.sda_h_oe <= 1'b0;
            if (phase == 2'h1) link.scl_h_oe <= 1'b0;
            if (phase == 2'h2) link.sda_h_oe <= 1'b1;
            if (phase == 2'h3) begin
              link.scl_h_oe <= 1'b1;
              tx <= {dev_addr, 1'b1};
              byte_no <= 3'h3;
              state <= gpio_pkg::HS_BIT;
            end
          end
          gpio_pkg::HS_STOP: begin
            if (phase == 2'h0) link.sda_h_oe <= 1'b1;
            if (phase == 2'h1) link.scl_h_oe <= 1'b0;
            if (phase == 2'h2) link.sda_h_oe <= 1'b0;
            if (phase == 2'h3) begin
              busy <= 1'b0;
              state <= gpio_pkg::HS_IDLE;
            end
          end
          default: state <= gpio_pkg::HS_IDLE;
        endcase
      end
    end
  end
endmodule

// ===== sim/gpio_link_checker.sv
// Checker for the serial bus and pin lines between the host and device ends.
module gpio_link_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Line drivers
  input wire logic sda_h_oe,
  input wire logic sda_d_oe,
  input wire logic [5:0] gpio_d_oe,
  // Resolved lines
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  idle_reset_a: assert property (disable iff (1'b0) sys_rst |=> !sda_d_oe && scl && sda)
    else $error("lines not idle after reset");
  pins_reset_a: assert property (disable iff (1'b0) sys_rst |=> gpio_d_oe == 6'h00)
    else $error("pins driven after reset");
  sda_scl_low_a: assert property ($changed(sda_d_oe) |-> !scl && !$past(scl))
    else $error("device moved sda with scl high");
  answer_late_a: assert property ($rose(sda_d_oe) |-> !$past(scl, 3))
    else $error("device drove sda too soon");
  sda_release_a: assert property ($rose(sda_d_oe) |-> ##[1:500] $fell(sda_d_oe))
    else $error("device held sda too long");
  start_host_a: assert property ($fell(sda) && scl && $past(scl) |-> sda_h_oe)
    else $error("start without host drive");
  high_phase_a: assert property ($rose(scl) |=> scl [*8])
    else $error("scl high phase too short");
  // The bench straps two-wire mode on, so pins five and four carry the bus.
  bus_pins_a: assert property (gpio_d_oe[5:4] == 2'b00)
    else $error("bus pins driven as pins");
  cover property ($rose(sda_d_oe));
  cover property ($fell(sda) && scl);
  cover property (gpio_d_oe[2]);
endmodule

// ===== sim/tb_top.sv
// Testbench: the AXI4-Lite host end drives the device end over the serial link.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = '0;
  logic sys_rst = '1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, st;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, b;
  logic [4:0] rail_good = '0, rail_on;
  logic [3:0] softstart_done = '0;
  logic [16:0] flt = '0;
  logic [35:0] phase_offset_deg;
  logic main_clock_external, config_loaded, ext_sync_clock;
  int errors = 0, checks_done = 0;
  gpio_link_if link();
  gpio_i2c_host u_gpio_i2c_host (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .link(link.host));
  gpio_i2c_device u_gpio_i2c_device (.clk, .sys_rst, .link(link.device), .two_wire_mode(1'b1),
    .nv_address(7'h2a), .otp_valid(1'b0), .otp_pin_function(48'h0), .rail_good, .softstart_done,
    .overcurrent_fault(flt[3:0]), .overcurrent_warn(flt[7:4]), .overvoltage_fault(flt[11:8]),
    .input_undervoltage_fault(flt[13:12]), .input_undervoltage_warn(flt[15:14]),
    .over_temp(flt[16]), .rail_on, .phase_offset_deg, .main_clock_external,
    .ext_sync_clock, .config_loaded);
  gpio_link_checker u_gpio_link_checker (.clk, .sys_rst, .sda_h_oe(link.sda_h_oe),
    .sda_d_oe(link.sda_d_oe), .gpio_d_oe(link.gpio_d_oe), .scl(link.scl), .sda(link.sda));
  initial forever #50 clk = ~clk;
  task automatic chk(input string n, input logic [35:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
    end while (!s_axi_bvalid);
    b = s_axi_bresp;
    s_axi_bready <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= '0;
    end while (!s_axi_rvalid);
    st = s_axi_rdata;
    s_axi_rready <= '0;
  endtask
  task automatic i2c(input logic r, input logic [6:0] a, input logic [7:0] x, d);
    wr(gpio_pkg::AXI_CMD, {1'b1, 6'h00, r, 1'b0, a, x, d});
    do rd(gpio_pkg::AXI_STATUS); while (st[0]);
  endtask
  task automatic put(input logic [7:0] x, d);
    i2c('0, 7'h2a, x, d);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #9_000_000;
    errors++;
    wrap_up;
  end
  initial begin
    link.gpio_s_o = '0;
    link.gpio_s_oe = '0;
    repeat (20) @(posedge clk);
    sys_rst <= '0;
    repeat (2) @(posedge clk);
    chk("loaded", config_loaded, 1'b1);
    chk("ext clock off", main_clock_external, 1'b0);
    put(gpio_pkg::REG_POLARITY, 8'h3f);
    i2c('1, 7'h2a, gpio_pkg::REG_POLARITY, 8'h00);
    chk("polarity", st[15:8], 8'h0f);
    put(gpio_pkg::REG_POLARITY, 8'h01);
    put(gpio_pkg::REG_FUNC0, {gpio_pkg::FN_ENABLE, 5'h11});
    link.gpio_s_oe <= 6'h01;
    repeat (10) @(posedge clk);
    chk("rails on", rail_on, 5'h11);
    link.gpio_s_o <= 6'h01;
    repeat (10) @(posedge clk);
    chk("rails off", rail_on, 5'h00);
    put(gpio_pkg::REG_RAIL_CMD, 8'h04);
    chk("rail command", rail_on, 5'h04);
    $display("rail enable test done");
    rail_good <= 5'h13;
    softstart_done <= 4'h5;
    put(8'h02, {gpio_pkg::FN_PGOOD, 5'h03});
    i2c('1, 7'h2a, gpio_pkg::REG_STATUS, 8'h00);
    chk("status", st[15:8], 8'h53);
    chk("good on", link.gpio[1], 1'b1);
    rail_good <= 5'h11;
    repeat (10) @(posedge clk);
    chk("good off", link.gpio[1], 1'b0);
    for (int i = 0; i < 17; i++) begin
      flt <= 17'h1ffff ^ (17'h00001 << i);
      put(8'h03, {gpio_pkg::FN_FAULT, 5'(i)});
      chk("fault idle", link.gpio[2], 1'b0);
      flt <= 17'h00001 << i;
      repeat (10) @(posedge clk);
      chk("fault shown", link.gpio[2], 1'b1);
    end
    $display("status and fault test done");
    put(gpio_pkg::REG_PHASE, 8'he4);
    chk("phase four", phase_offset_deg, {9'h10e, 9'h0b4, 9'h05a, 9'h000});
    put(gpio_pkg::REG_CONFIG, 8'h05);
    put(gpio_pkg::REG_PHASE, 8'h05);
    chk("phase three", phase_offset_deg, {9'h000, 9'h000, 9'h078, 9'h078});
    chk("ext clock on", main_clock_external, 1'b1);
    $display("phase test done");
    i2c('0, 7'h2b, gpio_pkg::REG_RAIL_CMD, 8'h1f);
    chk("nack", st[1], 1'b1);
    chk("rails kept", rail_on, 5'h04);
    put(gpio_pkg::REG_CONFIG, 8'h07);
    link.gpio_s_o <= 6'h09;
    link.gpio_s_oe <= 6'h09;
    i2c('0, 7'h2b, gpio_pkg::REG_RAIL_CMD, 8'h02);
    chk("pin address", rail_on, 5'h02);
    i2c('0, 7'h2b, 8'h04, {gpio_pkg::FN_EXTCLK, 5'h00});
    repeat (10) @(posedge clk);
    chk("ext sync high", ext_sync_clock, 1'b1);
    link.gpio_s_o <= 6'h01;
    repeat (10) @(posedge clk);
    chk("ext sync low", ext_sync_clock, 1'b0);
    wr(8'h10, 32'h0000_0000);
    chk("unmapped", b, gpio_pkg::RESP_SLVERR);
    $display("address test done");
    wrap_up;
  end
endmodule
